// >>> src/ppp_port.sv
// parallel programming port, device side
`timescale 1ns/1ns
`default_nettype none
module ppp_port #(
  parameter int FLASH_PAGE_WORDS = 64,
  parameter int EE_PAGE_BYTES = 4,
  parameter logic [15:0] ERASE_CYCLES = 16'h0200,
  parameter logic [15:0] PROG_CYCLES = 16'h0100,
  parameter logic [15:0] FUSE_CYCLES = 16'h0040,
  parameter logic [7:0] SIG_BYTE0 = 8'h5a, // arbitrary value
  parameter logic [7:0] SIG_BYTE1 = 8'h21, // arbitrary value
  parameter logic [7:0] SIG_BYTE2 = 8'h07, // arbitrary value
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // programming pins
  input wire logic i_crystal_input_strobe,
  input wire logic i_xtal_action_bit0,
  input wire logic i_xtal_action_bit1,
  input wire logic i_byte_select_one,
  input wire logic i_byte_select_two,
  input wire logic i_page_buffer_latch,
  input wire logic i_write_strobe_n,
  input wire logic i_output_enable_n,
  input wire logic i_reset_pin_n,
  input wire logic i_reset_high_voltage,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  output logic o_ready_busy_n,
  // nonvolatile array
  output logic o_nv_we,
  output logic o_nv_eeprom,
  output logic [15:0] o_nv_addr,
  output logic [15:0] o_nv_wdata,
  input wire logic [15:0] i_nv_rdata,
  output logic o_nv_erase,
  output logic o_nv_erase_eeprom,
  // status
  output logic o_prog_mode,
  output logic [23:0] o_fuse_active,
  output logic o_eeprom_keep,
  output logic [7:0] o_lock_bits,
  output logic [7:0] o_oscillator_trim_register
);
  localparam int FW = $clog2(FLASH_PAGE_WORDS);
  localparam logic [FW-1:0] F_LAST = FW'(FLASH_PAGE_WORDS - 1);
  localparam logic [FW-1:0] E_LAST = FW'(EE_PAGE_BYTES - 1);

  typedef struct packed {
    logic [ppp_pkg::PIN_W-1:0] s1;
    logic [ppp_pkg::PIN_W-1:0] s2;
    logic [ppp_pkg::PIN_W-1:0] prv;
    ppp_pkg::ppp_state_t st;
    logic [7:0] cmd;
    logic [7:0] ahi;
    logic [7:0] alo;
    logic [7:0] dlo;
    logic [7:0] dhi;
    logic [FLASH_PAGE_WORDS-1:0][15:0] pbuf;
    logic [FLASH_PAGE_WORDS-1:0] pval;
    logic [FW-1:0] idx;
    logic [15:0] tmr;
    logic [2:0][7:0] fuse;
    logic [2:0][7:0] fact;
    logic [7:0] lock;
    logic [7:0] dout;
    logic [7:0] trim;
    logic prog;
    logic arm;
    logic rdy;
    logic we;
    logic erase;
    logic ee_erase;
    logic [2:0] xcnt;
    logic [3:0] grd;
    logic [15:0] nva;
    logic [15:0] nvd;
  } ppp_regs_t;

  ppp_regs_t r_q;
  ppp_regs_t r_d;

  // page slot of the current address, eeprom pages are narrower
  function automatic logic [FW-1:0] slot(input logic [7:0] lo,
                                         input logic ee);
    slot = ee ? (FW'(lo) & E_LAST) : (FW'(lo) & F_LAST);
  endfunction : slot

  // word address with the in-page bits replaced by a slot
  function automatic logic [15:0] page_addr(input logic [15:0] a,
                                            input logic [FW-1:0] i,
                                            input logic ee);
    logic [15:0] m;
    m = ee ? 16'(E_LAST) : 16'(F_LAST);
    page_addr = (a & ~m) | (16'(i) & m);
  endfunction : page_addr

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic [ppp_pkg::PIN_W-1:0] s;
    logic [ppp_pkg::PIN_W-1:0] p;
    logic [7:0] din;
    logic [3:0] pat;
    logic xrise;
    logic wrfall;
    logic plrise;
    logic ee;
    logic [1:0] fsel;
    s = r_q.s2;
    p = r_q.prv;
    din = s[ppp_pkg::P_DAT +: 8];
    pat = {s[ppp_pkg::P_PGL], s[ppp_pkg::P_XA1], s[ppp_pkg::P_XA0],
           s[ppp_pkg::P_BS1]};
    xrise = s[ppp_pkg::P_XTAL] & ~p[ppp_pkg::P_XTAL];
    wrfall = ~s[ppp_pkg::P_WRN] & p[ppp_pkg::P_WRN];
    plrise = s[ppp_pkg::P_PGL] & ~p[ppp_pkg::P_PGL];
    ee = (r_q.cmd == ppp_pkg::CMD_WEE) || (r_q.cmd == ppp_pkg::CMD_REE);
    fsel = {s[ppp_pkg::P_BS2], s[ppp_pkg::P_BS1]};
    r_d = r_q;
    // two flop pin synchroniser
    r_d.s1 = {i_data, i_reset_pin_n, i_reset_high_voltage, i_output_enable_n,
              i_write_strobe_n, i_page_buffer_latch, i_byte_select_two,
              i_byte_select_one, i_xtal_action_bit1, i_xtal_action_bit0,
              i_crystal_input_strobe};
    r_d.s2 = r_q.s1;
    r_d.prv = r_q.s2;
    r_d.we = 1'b0;
    r_d.erase = 1'b0;
    r_d.nva = {r_q.ahi, r_q.alo};

    // entry: strobes under reset low, pattern, then high voltage
    if (!r_q.prog)
    begin
      if (s[ppp_pkg::P_RSTN])
        r_d.xcnt = 3'h0;
      else if (xrise && r_q.xcnt < ppp_pkg::XTAL_TOGGLES)
        r_d.xcnt = r_q.xcnt + 3'h1;
      if (s[ppp_pkg::P_HV] && !p[ppp_pkg::P_HV] &&
          r_q.xcnt >= ppp_pkg::XTAL_TOGGLES && pat == 4'h0)
      begin
        r_d.arm = 1'b1;
        r_d.grd = 4'(ppp_pkg::ENTRY_GUARD_CYC);
      end
      if (r_q.arm)
      begin
        r_d.grd = r_q.grd - 4'h1;
        if (pat != 4'h0 || !s[ppp_pkg::P_HV])
        begin
          r_d.arm = 1'b0;
          r_d.xcnt = 3'h0;
        end
        else if (r_q.grd == 4'h1)
        begin
          r_d.arm = 1'b0;
          r_d.prog = 1'b1;
          r_d.fact = r_q.fuse;
          r_d.cmd = ppp_pkg::CMD_NOP;
        end
      end
    end
    else if (!s[ppp_pkg::P_HV])
    begin
      // leaving programming mode makes fuse changes active
      r_d.prog = 1'b0;
      r_d.xcnt = 3'h0;
      r_d.fact = r_q.fuse;
    end

    // operation sequencer
    unique case (r_q.st)
      ppp_pkg::ST_IDLE:
      begin
        // loads and strobes only while ready
        if (r_q.prog && xrise)
        begin
          unique case ({s[ppp_pkg::P_XA1], s[ppp_pkg::P_XA0]})
            ppp_pkg::ACT_ADDR:
              if (s[ppp_pkg::P_BS1]) r_d.ahi = din;
              else r_d.alo = din;
            ppp_pkg::ACT_DATA:
              if (s[ppp_pkg::P_BS1]) r_d.dhi = din;
              else r_d.dlo = din;
            ppp_pkg::ACT_CMD:
            begin
              r_d.cmd = din;
              if (din == ppp_pkg::CMD_NOP)
                r_d.pval = '0;
            end
            default: ;
          endcase
        end
        if (r_q.prog && plrise && s[ppp_pkg::P_BS1])
        begin
          // fill the page buffer slot picked by the low address
          r_d.pbuf[slot(r_q.alo, ee)] =
            ee ? {8'h00, r_q.dlo} : {r_q.dhi, r_q.dlo};
          r_d.pval[slot(r_q.alo, ee)] = 1'b1;
        end
        if (r_q.prog && wrfall)
        begin
          unique case (r_q.cmd)
            ppp_pkg::CMD_ERASE:
            begin
              r_d.erase = 1'b1;
              r_d.ee_erase = r_q.fuse[1][ppp_pkg::FUSE_HI_EEKEEP];
              r_d.tmr = ERASE_CYCLES;
              r_d.rdy = 1'b0;
              r_d.st = ppp_pkg::ST_ERASE;
            end
            ppp_pkg::CMD_WFLASH, ppp_pkg::CMD_WEE:
            begin
              r_d.idx = '0;
              r_d.rdy = 1'b0;
              r_d.st = ppp_pkg::ST_PROG;
            end
            ppp_pkg::CMD_WFUSE:
            begin
              // low, high or extended fuse byte, refused once locked
              if (r_q.lock[ppp_pkg::LOCK_FIRST])
              begin
                if (fsel == 2'h1) r_d.fuse[1] = r_q.dlo;
                else if (fsel == 2'h2) r_d.fuse[2] = r_q.dlo;
                else r_d.fuse[0] = r_q.dlo;
              end
              r_d.tmr = FUSE_CYCLES;
              r_d.rdy = 1'b0;
              r_d.st = ppp_pkg::ST_WAIT;
            end
            ppp_pkg::CMD_WLOCK:
            begin
              r_d.lock = r_q.lock & r_q.dlo; // lock bits only program
              r_d.tmr = FUSE_CYCLES;
              r_d.rdy = 1'b0;
              r_d.st = ppp_pkg::ST_WAIT;
            end
            default: ;
          endcase
        end
      end
      ppp_pkg::ST_ERASE:
      begin
        // fuses untouched; locks cleared only when memory is blank
        r_d.tmr = r_q.tmr - 16'h1;
        if (r_q.tmr <= 16'h1)
        begin
          r_d.lock = ppp_pkg::LOCK_RST;
          r_d.rdy = 1'b1;
          r_d.st = ppp_pkg::ST_IDLE;
        end
      end
      ppp_pkg::ST_PROG:
      begin
        // walk the buffer, writing every latched slot
        if (r_q.pval[r_q.idx])
        begin
          r_d.we = 1'b1;
          r_d.nva = page_addr({r_q.ahi, r_q.alo}, r_q.idx, ee);
          r_d.nvd = r_q.pbuf[r_q.idx];
        end
        r_d.idx = r_q.idx + FW'(1);
        if (r_q.idx == (ee ? E_LAST : F_LAST))
        begin
          r_d.pval = '0;
          r_d.tmr = PROG_CYCLES;
          r_d.st = ppp_pkg::ST_WAIT;
        end
      end
      ppp_pkg::ST_WAIT:
      begin
        r_d.tmr = r_q.tmr - 16'h1;
        if (r_q.tmr <= 16'h1)
        begin
          r_d.rdy = 1'b1;
          r_d.st = ppp_pkg::ST_IDLE;
        end
      end
    endcase

    // read data, selected by command and byte selects
    unique case (r_q.cmd)
      ppp_pkg::CMD_RFLASH:
        r_d.dout = s[ppp_pkg::P_BS1] ? i_nv_rdata[15:8] : i_nv_rdata[7:0];
      ppp_pkg::CMD_REE:
        r_d.dout = i_nv_rdata[7:0];
      ppp_pkg::CMD_RFUSE:
        unique case (fsel)
          2'h0: r_d.dout = r_q.fuse[0];
          2'h3: r_d.dout = r_q.fuse[1];
          2'h2: r_d.dout = r_q.fuse[2];
          default: r_d.dout = r_q.lock;
        endcase
      ppp_pkg::CMD_RSIG:
        // readable even when locked
        if (s[ppp_pkg::P_BS1])
          r_d.dout = (r_q.alo == 8'h00) ? CAL_BYTE : ppp_pkg::UNMAPPED;
        else if (r_q.alo == 8'h00) r_d.dout = SIG_BYTE0;
        else if (r_q.alo == 8'h01) r_d.dout = SIG_BYTE1;
        else if (r_q.alo == 8'h02) r_d.dout = SIG_BYTE2;
        else r_d.dout = ppp_pkg::UNMAPPED;
      default: r_d.dout = ppp_pkg::UNMAPPED;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; reset also models power-up of the fuse store
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      r_q <= '0;
      r_q.st <= ppp_pkg::ST_IDLE;
      r_q.cmd <= ppp_pkg::CMD_NOP;
      r_q.fuse <= {ppp_pkg::FUSE_EX_RST, ppp_pkg::FUSE_HI_RST,
                   ppp_pkg::FUSE_LO_RST};
      r_q.fact <= {ppp_pkg::FUSE_EX_RST, ppp_pkg::FUSE_HI_RST,
                   ppp_pkg::FUSE_LO_RST};
      r_q.lock <= ppp_pkg::LOCK_RST;
      r_q.dout <= ppp_pkg::UNMAPPED;
      r_q.trim <= CAL_BYTE;
      r_q.rdy <= 1'b1;
      r_q.s1 <= '1;
      r_q.s2 <= '1;
      r_q.prv <= '1;
    end
    else
      r_q <= r_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_data = r_q.dout;
  // driven only in programming mode with output enable low
  assign o_data_oe_n = ~(r_q.prog & ~r_q.s2[ppp_pkg::P_OEN]);
  assign o_ready_busy_n = r_q.rdy;
  assign o_nv_we = r_q.we;
  assign o_nv_eeprom = (r_q.cmd == ppp_pkg::CMD_WEE) ||
                       (r_q.cmd == ppp_pkg::CMD_REE);
  assign o_nv_addr = r_q.nva;
  assign o_nv_wdata = r_q.nvd;
  assign o_nv_erase = r_q.erase;
  assign o_nv_erase_eeprom = r_q.erase & r_q.ee_erase;
  assign o_prog_mode = r_q.prog;
  assign o_fuse_active = r_q.fact;
  // the keep fuse acts as soon as it is written
  assign o_eeprom_keep = ~r_q.fuse[1][ppp_pkg::FUSE_HI_EEKEEP];
  assign o_lock_bits = r_q.lock;
  assign o_oscillator_trim_register = r_q.trim;
endmodule : ppp_port
`default_nettype wire

// >>> src/ppp_pkg.sv
// constants, commands and states of the parallel programming port
package ppp_pkg;
  // timing
  localparam int CLK_NS = 8;
  localparam int ENTRY_GUARD_NS = 100;
  localparam int ENTRY_GUARD_CYC = (ENTRY_GUARD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] XTAL_TOGGLES = 3'h6;
  // positions in the synchronised pin vector
  localparam int P_XTAL = 0;
  localparam int P_XA0 = 1;
  localparam int P_XA1 = 2;
  localparam int P_BS1 = 3;
  localparam int P_BS2 = 4;
  localparam int P_PGL = 5;
  localparam int P_WRN = 6;
  localparam int P_OEN = 7;
  localparam int P_HV = 8;
  localparam int P_RSTN = 9;
  localparam int P_DAT = 10;
  localparam int PIN_W = 18;
  // strobe actions
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  // command bytes
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WFUSE = 8'h40;
  localparam logic [7:0] CMD_WLOCK = 8'h20;
  localparam logic [7:0] CMD_WFLASH = 8'h10;
  localparam logic [7:0] CMD_WEE = 8'h11;
  localparam logic [7:0] CMD_RSIG = 8'h08;
  localparam logic [7:0] CMD_RFUSE = 8'h04;
  localparam logic [7:0] CMD_RFLASH = 8'h02;
  localparam logic [7:0] CMD_REE = 8'h03;
  // fuse and lock reset values, bit positions
  localparam logic [7:0] FUSE_LO_RST = 8'h62;
  localparam logic [7:0] FUSE_HI_RST = 8'h99;
  localparam logic [7:0] FUSE_EX_RST = 8'hff;
  localparam logic [7:0] LOCK_RST = 8'hff;
  localparam int FUSE_HI_EEKEEP = 3;
  localparam int LOCK_FIRST = 0;
  localparam logic [7:0] UNMAPPED = 8'hff;
  typedef enum {ST_IDLE, ST_ERASE, ST_PROG, ST_WAIT} ppp_state_t;
endpackage : ppp_pkg

// >>> bench/ppp_port_assertions.sv
// concurrent checks on the programming port pins
`timescale 1ns/1ns
`default_nettype none
module ppp_port_assertions #(
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // programmer strobes
  input wire logic i_write_strobe_n,
  input wire logic i_output_enable_n,
  // device outputs
  input wire logic o_data_oe_n,
  input wire logic o_ready_busy_n,
  input wire logic o_nv_we,
  input wire logic o_nv_erase,
  input wire logic o_nv_erase_eeprom,
  input wire logic o_eeprom_keep,
  input wire logic [7:0] o_lock_bits,
  input wire logic [7:0] o_oscillator_trim_register
);
  localparam int ERASE_MAX = 600;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  //////////////////////////////////////////////////////////////////////////
  // bus direction
  property p_drive; !o_data_oe_n |-> !$past(i_output_enable_n, 2); endproperty
  property p_release; i_output_enable_n [*3] |=> o_data_oe_n; endproperty
  // busy handshake, erase results and trim load after reset
  property p_busy_cause;
    $fell(o_ready_busy_n) |-> !$past(i_write_strobe_n, 3);
  endproperty
  property p_busy_min; $fell(o_ready_busy_n) |-> !o_ready_busy_n [*8];
  endproperty
  property p_erase_busy; o_nv_erase |-> !o_ready_busy_n; endproperty
  property p_erase_end;
    o_nv_erase |-> ##[1:ERASE_MAX] (o_ready_busy_n && o_lock_bits == 8'hff);
  endproperty
  property p_keep; o_nv_erase_eeprom |-> o_nv_erase && !o_eeprom_keep;
  endproperty
  property p_we_busy; o_nv_we |-> !o_ready_busy_n; endproperty
  property p_trim; $fell(i_reset) |-> o_oscillator_trim_register == CAL_BYTE;
  endproperty
  //////////////////////////////////////////////////////////////////////////
  a_drive: assert property (p_drive)
    else $error("data bus driven without output enable");
  a_release: assert property (p_release)
    else $error("data bus not released");
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy without write strobe");
  a_busy_min: assert property (p_busy_min)
    else $error("busy too short");
  a_erase_busy: assert property (p_erase_busy)
    else $error("erase while ready");
  a_erase_end: assert property (p_erase_end)
    else $error("erase end without cleared locks");
  a_keep: assert property (p_keep)
    else $error("eeprom erased with keep fuse");
  a_we_busy: assert property (p_we_busy)
    else $error("array write while ready");
  a_trim: assert property (p_trim)
    else $error("trim not loaded by reset");
  // main scenarios
  c_erase: cover property (o_nv_erase);
  c_write: cover property (o_nv_we);
  c_read: cover property (!o_data_oe_n);
endmodule : ppp_port_assertions
`default_nettype wire

// >>> bench/ppp_nv_model.sv
// nonvolatile array model behind the port
`timescale 1ns/1ns
`default_nettype none
module ppp_nv_model (
  // clock
  input wire logic i_core_clk,
  // array access
  input wire logic i_we,
  input wire logic i_eeprom,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_erase,
  input wire logic i_erase_eeprom,
  output logic [15:0] o_rdata
);
  logic [15:0] fl_q [256];
  logic [15:0] ee_q [256];
  // arbitrary contents before the first erase
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      fl_q[i] = 16'h1200 + 16'(i);
      ee_q[i] = 16'h0055;
    end
  end
  // erase and word writes
  always @(posedge i_core_clk)
  begin
    for (int i = 0; i < 256; i++)
    begin
      if (i_erase)
        fl_q[i] <= 16'hffff;
      if (i_erase && i_erase_eeprom)
        ee_q[i] <= 16'hffff;
    end
    if (i_we && i_eeprom)
      ee_q[i_addr[7:0]] <= i_wdata;
    if (i_we && !i_eeprom)
      fl_q[i_addr[7:0]] <= i_wdata;
  end
  // addressed word, same cycle
  assign o_rdata = i_eeprom ? ee_q[i_addr[7:0]] : fl_q[i_addr[7:0]];
endmodule : ppp_nv_model
`default_nettype wire

// >>> bench/tb_top.sv
// testbench for the parallel programming port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [7:0] SIG0 = 8'h3a; // arbitrary value
  localparam logic [7:0] SIG1 = 8'h4b; // arbitrary value
  localparam logic [7:0] SIG2 = 8'h5c; // arbitrary value
  localparam logic [7:0] CAL = 8'h6d; // arbitrary value
  logic clk, rst, xs, bs1, bs2, pgl, wrn, oen, rstn, hv;
  logic o_data_oe_n, rdy, we, eesel, er, er_ee, pm, keep;
  logic [1:0] xa;
  logic [7:0] din, bus, o_data, lock, trim;
  logic [15:0] addr, wdata, rdata;
  logic [23:0] fuse;
  int fail_count, n_checks, n_we, n_er, n_ee;
  // bus level: device when enabled, else programmer data, inverted while output enable is low
  assign bus = !o_data_oe_n ? o_data : (oen ? din : ~din);
  ppp_port #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2),
    .CAL_BYTE(CAL)) u_ppp_port (.i_core_clk(clk), .i_reset(rst),
    .i_crystal_input_strobe(xs), .i_xtal_action_bit0(xa[0]),
    .i_xtal_action_bit1(xa[1]), .i_byte_select_one(bs1),
    .i_byte_select_two(bs2), .i_page_buffer_latch(pgl),
    .i_write_strobe_n(wrn), .i_output_enable_n(oen), .i_reset_pin_n(rstn),
    .i_reset_high_voltage(hv), .i_data(bus), .o_data(o_data),
    .o_data_oe_n(o_data_oe_n), .o_ready_busy_n(rdy), .o_nv_we(we),
    .o_nv_eeprom(eesel), .o_nv_addr(addr), .o_nv_wdata(wdata),
    .i_nv_rdata(rdata), .o_nv_erase(er), .o_nv_erase_eeprom(er_ee),
    .o_prog_mode(pm), .o_fuse_active(fuse), .o_eeprom_keep(keep),
    .o_lock_bits(lock), .o_oscillator_trim_register(trim));
  ppp_nv_model u_ppp_nv_model (.i_core_clk(clk), .i_we(we), .i_eeprom(eesel),
    .i_addr(addr), .i_wdata(wdata), .i_erase(er), .i_erase_eeprom(er_ee),
    .o_rdata(rdata));
  // clock and array pulse counters
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    n_we += int'(we === 1'b1);
    n_er += int'(er === 1'b1);
    n_ee += int'(er_ee === 1'b1);
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // one strobe load of address, data or command
  task automatic ld(input logic [1:0] a, input logic b1, input logic [7:0] d);
    xa = a;
    bs1 = b1;
    din = d;
    tick(32);
    xs = 1'b1;
    tick(32);
    xs = 1'b0;
    tick(32);
  endtask : ld
  task automatic cmd(input logic [7:0] c);
    ld(ppp_pkg::ACT_CMD, 1'b0, c);
  endtask : cmd
  task automatic adr(input logic [7:0] a);
    ld(ppp_pkg::ACT_ADDR, 1'b0, a);
  endtask : adr
  task automatic latch;
    bs1 = 1'b1;
    tick(4);
    pgl = 1'b1;
    tick(32);
    pgl = 1'b0;
    tick(32);
  endtask : latch
  task automatic wr(input logic b1, input logic b2);
    int k;
    bs1 = b1;
    bs2 = b2;
    tick(4);
    wrn = 1'b0;
    tick(4);
    chk(rdy, 1'b0);
    tick(28);
    wrn = 1'b1;
    k = 0;
    while (rdy !== 1'b1 && k < 1000)
    begin
      tick(1);
      k++;
    end
    chk(rdy, 1'b1);
  endtask : wr
  task automatic rd(input logic b1, input logic b2, input logic [7:0] e);
    bs1 = b1;
    bs2 = b2;
    tick(4);
    oen = 1'b0;
    tick(6);
    chk(o_data_oe_n, 1'b0);
    chk(bus, e);
    tick(26);
    oen = 1'b1;
    tick(6);
    chk(o_data_oe_n, 1'b1);
    tick(26);
  endtask : rd
  task automatic enter(input logic bad);
    hv = 1'b0;
    tick(32);
    repeat (6)
    begin
      xs = 1'b1;
      tick(32);
      xs = 1'b0;
      tick(32);
    end
    tick(16);
    hv = 1'b1;
    if (bad)
    begin
      tick(4);
      xa = 2'h1;
      tick(32);
      xa = 2'h0;
    end
    else
      tick(6250);
  endtask : enter
  //////////////////////////////////////////////////////////////////////////
  task automatic t_entry;
    enter(1'b1);
    chk(pm, 1'b0);
    enter(1'b0);
    chk(pm, 1'b1);
    chk(fuse, 24'hff9962);
  endtask : t_entry
  task automatic t_sig;
    logic [7:0] s [3];
    s = '{SIG0, SIG1, SIG2};
    cmd(ppp_pkg::CMD_RSIG);
    for (int i = 0; i < 3; i++)
    begin
      adr(8'(i));
      rd(1'b0, 1'b0, s[i]);
    end
    adr(8'h00);
    rd(1'b1, 1'b0, CAL);
  endtask : t_sig
  task automatic t_erase(input int e_er, input int e_ee);
    cmd(ppp_pkg::CMD_ERASE);
    wr(1'b0, 1'b0);
    chk(24'(n_er), 24'(e_er));
    chk(24'(n_ee), 24'(e_ee));
    chk(lock, 8'hff);
  endtask : t_erase
  task automatic t_fuse;
    cmd(ppp_pkg::CMD_WFUSE);
    ld(ppp_pkg::ACT_DATA, 1'b0, 8'h91);
    wr(1'b1, 1'b0);
    chk(keep, 1'b1);
    chk(fuse, 24'hff9962);
    cmd(ppp_pkg::CMD_RFUSE);
    rd(1'b1, 1'b1, 8'h91);
    rd(1'b0, 1'b0, 8'h62);
    rd(1'b0, 1'b1, 8'hff);
  endtask : t_fuse
  task automatic t_mem;
    cmd(ppp_pkg::CMD_WEE);
    adr(8'h00);
    ld(ppp_pkg::ACT_DATA, 1'b0, 8'h3c);
    latch();
    wr(1'b0, 1'b0);
    chk(24'(n_we), 24'h1);
    cmd(ppp_pkg::CMD_WFLASH);
    ld(ppp_pkg::ACT_ADDR, 1'b1, 8'h00);
    for (int i = 1; i < 3; i++)
    begin
      adr(8'(i));
      ld(ppp_pkg::ACT_DATA, 1'b0, 8'ha0 + 8'(i));
      ld(ppp_pkg::ACT_DATA, 1'b1, 8'hb0 + 8'(i));
      latch();
    end
    wr(1'b0, 1'b0);
    chk(24'(n_we), 24'h3);
    cmd(ppp_pkg::CMD_RFLASH);
    rd(1'b0, 1'b0, 8'ha2);
    rd(1'b1, 1'b0, 8'hb2);
    cmd(ppp_pkg::CMD_REE);
    adr(8'h00);
    rd(1'b0, 1'b0, 8'h3c);
  endtask : t_mem
  task automatic t_keep;
    t_erase(2, 1);
    cmd(ppp_pkg::CMD_RFLASH);
    adr(8'h02);
    rd(1'b0, 1'b0, 8'hff);
    cmd(ppp_pkg::CMD_REE);
    adr(8'h00);
    rd(1'b0, 1'b0, 8'h3c);
    cmd(ppp_pkg::CMD_RFUSE);
    rd(1'b1, 1'b1, 8'h91);
  endtask : t_keep
  // no-operation drops latched slots; loads while busy are ignored
  task automatic t_nop;
    int k;
    cmd(ppp_pkg::CMD_WFLASH);
    adr(8'h05);
    ld(ppp_pkg::ACT_DATA, 1'b0, 8'h55);
    latch();
    cmd(ppp_pkg::CMD_NOP);
    cmd(ppp_pkg::CMD_WFLASH);
    wrn = 1'b0;
    tick(32);
    wrn = 1'b1;
    cmd(ppp_pkg::CMD_RFUSE);
    k = 0;
    while (rdy !== 1'b1 && k < 1000)
    begin
      tick(1);
      k++;
    end
    chk(rdy, 1'b1);
    chk(24'(n_we), 24'h3);
    rd(1'b0, 1'b0, 8'hff);
  endtask : t_nop
  task automatic t_lock;
    cmd(ppp_pkg::CMD_WLOCK);
    ld(ppp_pkg::ACT_DATA, 1'b0, 8'hfe);
    wr(1'b0, 1'b0);
    chk(lock, 8'hfe);
    cmd(ppp_pkg::CMD_WFUSE);
    ld(ppp_pkg::ACT_DATA, 1'b0, 8'h00);
    wr(1'b0, 1'b0);
    cmd(ppp_pkg::CMD_RFUSE);
    rd(1'b0, 1'b0, 8'h62);
    rd(1'b1, 1'b0, 8'hfe);
    cmd(ppp_pkg::CMD_RSIG);
    adr(8'h00);
    rd(1'b0, 1'b0, SIG0);
  endtask : t_lock
  task automatic t_exit;
    hv = 1'b0;
    tick(8);
    chk(pm, 1'b0);
    chk(fuse, 24'hff9162);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(2);
    chk(trim, CAL);
  endtask : t_exit
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {rst, wrn, oen} = 3'h7;
    {xs, bs1, bs2, pgl, rstn, hv} = 6'h00;
    xa = 2'h0;
    din = 8'h00;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(2);
    t_entry();
    t_sig();
    t_erase(1, 1);
    t_fuse();
    t_mem();
    t_keep();
    t_nop();
    t_lock();
    t_exit();
    stop_test();
  end
  // watchdog against a hang
  initial
  begin
    #400000;
    fail_count++;
    stop_test();
  end
endmodule : tb_top
bind ppp_port ppp_port_assertions #(.CAL_BYTE(CAL_BYTE))
  u_ppp_port_assertions (.i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_write_strobe_n(i_write_strobe_n), .i_output_enable_n(i_output_enable_n),
  .o_data_oe_n(o_data_oe_n), .o_ready_busy_n(o_ready_busy_n),
  .o_nv_we(o_nv_we), .o_nv_erase(o_nv_erase),
  .o_nv_erase_eeprom(o_nv_erase_eeprom), .o_eeprom_keep(o_eeprom_keep),
  .o_lock_bits(o_lock_bits),
  .o_oscillator_trim_register(o_oscillator_trim_register));
`default_nettype wire
